// ### src/sipo_defines.svh
// Purpose: Constants for the serial-in parallel-out latch
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef SIPO_DEFINES_SVH
`define SIPO_DEFINES_SVH
`define SIPO_WIDTH 8
`define SIPO_ZERO 8'h00
`define SIPO_SYNC_STAGES 2
`define SIPO_PIN_IDLE 5'h1C
`define SIPO_RUN_ZERO 4'h0
`define SIPO_RUN_ONE 4'h1
`define SIPO_RUN_MAX 4'hF
`endif

// ### src/sipo_pkg.sv
// Purpose: Shared types for the serial-in parallel-out latch
// Assumes: Defines header is present
// Notes: Types only
`include "sipo_defines.svh"
`default_nettype none
package sipo_pkg;
  typedef logic [`SIPO_WIDTH-1:0] sipo_byte_t;
endpackage
`default_nettype wire

// ### src/sipo_edge_if.sv
// Purpose: Carries synchronised pin levels and clock edges to the core
// Assumes: One sys_clk domain
// Notes: Filled by the sampler, read by the top
`default_nettype none
interface sipo_edge_if;
  logic shiftRise;
  logic storeRise;
  logic clearActive;
  logic serialLevel;
  logic outEnableN;
  modport sampler (output shiftRise, output storeRise, output clearActive,
                   output serialLevel, output outEnableN);
  modport core (input shiftRise, input storeRise, input clearActive,
                input serialLevel, input outEnableN);
endinterface
`default_nettype wire

// ### src/sipo_pin_sampler.sv
// Purpose: Two-flop synchronisers and rising-edge finders for the pins
// Assumes: Pin clocks far slower than sys_clk
// Notes: Edge detectors read only the second synchroniser stage
`include "sipo_defines.svh"
`default_nettype none
module sipo_pin_sampler (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Raw pins: shift clock, storage clock, clear, data, output enable
  input wire logic [4:0] pinRaw,
  // To core
  sipo_edge_if.sampler edges
);
  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic [1:0] prevClk_r;

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers; clear and enable rest inactive
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      meta_r <= `SIPO_PIN_IDLE;
      sync_r <= `SIPO_PIN_IDLE;
    end else begin
      meta_r <= pinRaw;
      sync_r <= meta_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      prevClk_r <= 2'h0;
    end else begin
      prevClk_r <= sync_r[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign edges.shiftRise = sync_r[0] & ~prevClk_r[0];
  assign edges.storeRise = sync_r[1] & ~prevClk_r[1];
  assign edges.clearActive = ~sync_r[2];
  assign edges.serialLevel = sync_r[3];
  assign edges.outEnableN = sync_r[4];
endmodule
`default_nettype wire

// ### src/sipo_latch.sv
// Purpose: Eight-stage shift register feeding a storage register
// Assumes: Pin clocks are sampled by sys_clk at 100 MHz
// Notes: Parallel outputs are two signals each; the bench resolves the wire
// Operation
// - Eight-stage shift register feeds an eight-bit storage register driving outputs.
// - Output enable high floats parallel outputs; cascade output keeps driving.
// - Output enable low drives parallel outputs with storage contents.
// - Separate shift and storage clocks, each acting on its rising edge.
// - Clear low zeroes all shift stages at once, overriding clock and data.
// - Shift edge loads serial data into stage one, others take predecessor.
// - Storage edge copies all shift stages into the storage register.
// - Last stage appears on a cascade pin for chaining devices.
// - Common clock: storage takes pre-shift contents, lagging one pulse.
`include "sipo_defines.svh"
`default_nettype none
module sipo_latch
  import sipo_pkg::*;
#(
  parameter int WIDTH = `SIPO_WIDTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Controller pins
  input wire logic serial_data_in,
  input wire logic shift_clock,
  input wire logic shift_clear_n,
  input wire logic storage_clock,
  input wire logic out_enable_n,
  // Parallel three-state outputs
  output logic [WIDTH-1:0] parallel_out,
  output logic [WIDTH-1:0] parallelOutEn,
  // Cascade
  output logic cascade_serial_out
);
  import sipo_pkg::*;

  sipo_edge_if edges ();
  logic [WIDTH-1:0] shift_r;
  logic [WIDTH-1:0] store_r;
  logic driveAll;

  ////////////////////////////////////////////////////////////////////////
  // Pin sampling; the clear is taken through the synchroniser as well,
  // trading two cycles of latency for freedom from metastability
  sipo_pin_sampler u_sampler (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pinRaw({out_enable_n, serial_data_in, shift_clear_n, storage_clock,
             shift_clock}),
    .edges(edges)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next shift contents; shared by the register and its checks
  function automatic logic [WIDTH-1:0] shift_next(input logic [WIDTH-1:0] cur,
                                                  input logic din);
    return {cur[WIDTH-2:0], din};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Shift register
  // Limitation: the clear is seen two to three cycles late, so a clear pulse
  // shorter than one sys_clk period may be lost entirely
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      shift_r <= WIDTH'(`SIPO_ZERO);
    end else if (edges.clearActive) begin
      shift_r <= WIDTH'(`SIPO_ZERO);
    end else if (edges.shiftRise) begin
      shift_r <= shift_next(shift_r, edges.serialLevel);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Storage register; reads the old shift value, so a shared clock lags
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      store_r <= WIDTH'(`SIPO_ZERO);
    end else if (edges.storeRise) begin
      store_r <= shift_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs; bit 0 is stage one
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      driveAll <= 1'b0;
    end else begin
      driveAll <= ~edges.outEnableN;
    end
  end

  assign parallel_out = store_r;
  assign parallelOutEn = {WIDTH{driveAll}};
  assign cascade_serial_out = shift_r[WIDTH-1];

  ////////////////////////////////////////////////////////////////////////
  // Check helper: counts cycles of a held clear, saturating, so that a long
  // clear is checked without a long repetition
  logic [3:0] clearRun_r;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      clearRun_r <= `SIPO_RUN_ZERO;
    end else if (!edges.clearActive) begin
      clearRun_r <= `SIPO_RUN_ZERO;
    end else if (clearRun_r != `SIPO_RUN_MAX) begin
      clearRun_r <= clearRun_r + `SIPO_RUN_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift register checks
  shift_load_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (edges.shiftRise && !edges.clearActive) |=>
    shift_r == shift_next($past(shift_r), $past(edges.serialLevel)))
    else $error("shift stage load wrong");
  shift_first_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (edges.shiftRise && !edges.clearActive) |=>
    shift_r[0] == $past(edges.serialLevel))
    else $error("first stage did not take serial data");
  shift_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!edges.shiftRise && !edges.clearActive) |=> $stable(shift_r))
    else $error("shift register changed without edge");
  data_ignored_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!edges.shiftRise && !edges.clearActive && $changed(edges.serialLevel)) |=>
    $stable(shift_r))
    else $error("serial data leaked without shift edge");
  store_free_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (edges.storeRise && !edges.shiftRise && !edges.clearActive) |=> $stable(shift_r))
    else $error("storage edge disturbed shift register");

  ////////////////////////////////////////////////////////////////////////
  // Clear and storage register checks
  clear_held_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clearRun_r != `SIPO_RUN_ZERO) |-> shift_r == '0)
    else $error("shift register not held clear");
  clear_wins_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (edges.clearActive && edges.shiftRise) |=> shift_r == '0)
    else $error("shift edge beat the clear");
  clear_cascade_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    edges.clearActive |=> !cascade_serial_out)
    else $error("cascade not cleared");
  clear_store_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (edges.clearActive && !edges.storeRise) |=> $stable(store_r))
    else $error("clear disturbed storage register");
  clear_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    edges.clearActive |=> shift_r == '0)
    else $error("clear did not zero shift register");
  store_copy_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    edges.storeRise |=> store_r == $past(shift_r))
    else $error("storage copy wrong");
  store_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !edges.storeRise |=> $stable(store_r))
    else $error("storage changed without edge");
  shared_lag_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (edges.storeRise && edges.shiftRise && !edges.clearActive) |=>
    (store_r == $past(shift_r) &&
     shift_r == shift_next($past(shift_r), $past(edges.serialLevel))))
    else $error("storage did not lag shift");
  store_in_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (edges.storeRise && edges.clearActive) |=> store_r == $past(shift_r))
    else $error("storage copy lost during clear");
  store_order_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    edges.storeRise |=> (parallel_out[0] == $past(shift_r[0]) &&
    parallel_out[WIDTH-1] == $past(shift_r[WIDTH-1])))
    else $error("parallel output order wrong");

  ////////////////////////////////////////////////////////////////////////
  // Output enable checks; the cascade pin is outside the enable
  float_out_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    edges.outEnableN |=> parallelOutEn == '0)
    else $error("outputs not floated");
  drive_out_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !edges.outEnableN |=> (parallelOutEn == '1 && parallel_out == store_r))
    else $error("outputs not driven");
  cascade_bit_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (edges.shiftRise && !edges.clearActive) |=>
    cascade_serial_out == $past(shift_r[WIDTH-2]))
    else $error("cascade output wrong");
  cascade_free_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (edges.outEnableN && edges.shiftRise && !edges.clearActive) |=>
    cascade_serial_out == $past(shift_r[WIDTH-2]))
    else $error("cascade stopped while outputs floated");
  cascade_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!edges.shiftRise && !edges.clearActive) |=> $stable(cascade_serial_out))
    else $error("cascade changed without shift edge");
  store_any_oe_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (edges.storeRise && edges.outEnableN) |=> store_r == $past(shift_r))
    else $error("storage copy lost while floated");
endmodule
`default_nettype wire

// ### testbench/sipo_ctl_model.sv
// Purpose: Controller model driving the latch pins
// Assumes: Pins change just after sys_clk rises
// Notes: Pulses last 40 ns, well above the sampler limit
`default_nettype none
module sipo_ctl_model (
  // Clock
  input wire logic sys_clk,
  // Pins to the latch
  output logic serialData,
  output logic shiftClk,
  output logic storeClk,
  output logic clearN,
  output logic oeN
);
  initial {serialData, shiftClk, storeClk, clearN, oeN} = 5'h03;
  // Shift and store go in separate pulses unless tied on purpose
  task automatic pulse(input logic sh, input logic st, input logic d);
    @(posedge sys_clk) serialData <= d;
    @(posedge sys_clk) {shiftClk, storeClk} <= {sh, st};
    repeat (4) @(posedge sys_clk);
    {shiftClk, storeClk} <= 2'h0;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic levels(input logic clr, input logic oe);
    @(posedge sys_clk) {clearN, oeN} <= {clr, oe};
    repeat (6) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Purpose: Self-checking bench for the serial-in parallel-out latch
// Assumes: Controller model drives every pin
// Notes: Parallel pins resolved here from the enables
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sipo_pkg::*;
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic sd, sc, st, clr, oe, cas;
  sipo_byte_t pout, pen;
  wire [7:0] pins;
  int fail_count = 0;
  int tests_run = 0;
  always #5 sys_clk = ~sys_clk;
  for (genvar i = 0; i < 8; i++) begin : g_pin
    assign pins[i] = pen[i] ? pout[i] : 1'hZ;
  end
  sipo_ctl_model i_ctl (.sys_clk(sys_clk), .serialData(sd), .shiftClk(sc),
    .storeClk(st), .clearN(clr), .oeN(oe));
  sipo_latch i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .serial_data_in(sd),
    .shift_clock(sc), .shift_clear_n(clr), .storage_clock(st), .out_enable_n(oe),
    .parallel_out(pout), .parallelOutEn(pen), .cascade_serial_out(cas));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    @(negedge sys_clk);
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic t_load();
    sipo_byte_t pat;
    pat = 8'hB4;
    check(pins, 8'hZZ);
    i_ctl.levels(1'h1, 1'h0);
    check(pins, 8'h00);
    for (int i = 7; i >= 0; i--) i_ctl.pulse(1'h1, 1'h0, pat[i]);
    check(pins, 8'h00);
    check({7'h00, cas}, 8'h01);
    i_ctl.pulse(1'h0, 1'h1, 1'h0);
    check(pins, 8'hB4);
    $display("load done");
  endtask
  task automatic t_tied();
    i_ctl.pulse(1'h1, 1'h1, 1'h1);
    check(pins, 8'hB4);
    i_ctl.pulse(1'h0, 1'h1, 1'h0);
    check(pins, 8'h69);
    i_ctl.pulse(1'h1, 1'h0, 1'h0);
    check({7'h00, cas}, 8'h01);
    $display("tied clocks done");
  endtask
  task automatic t_clear();
    i_ctl.levels(1'h0, 1'h0);
    i_ctl.pulse(1'h1, 1'h0, 1'h1);
    check({7'h00, cas}, 8'h00);
    i_ctl.pulse(1'h0, 1'h1, 1'h1);
    check(pins, 8'h00);
    i_ctl.levels(1'h1, 1'h1);
    check(pins, 8'hZZ);
    check({7'h00, cas}, 8'h00);
    $display("clear done");
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'h1;
    t_load();
    t_tied();
    t_clear();
    report_and_stop();
  end
  // Whole run is a few hundred cycles; this margin only catches a hang
  initial begin
    #50us;
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
